/* File: hw/ciwa_top.sv */
// Purpose : Input sequence: character transfer and full-word assembly
// Assumes : Peripheral resume and disconnect are asynchronous pins
// Notes   : Store requests leave through an eight-word FIFO
`default_nettype none

module ciwa_top
	import ciwa_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Peripheral pins
	input  wire logic [CHAR_W-1:0] in_char,
	input  wire logic              in_resume,
	input  wire logic              ext_disconnect,
	output var  logic              in_enable,
	// Instruction control
	input  wire logic              instr_start,
	input  wire logic              instr_repeat,
	input  wire logic [MODE_W-1:0] store_mode,
	input  wire logic              tape_reader_sel,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [ADDR_W-1:0] index_in,
	input  wire logic              select_mode,
	input  wire logic              select_fn,
	// Status
	output var  logic              input_loaded_lamp,
	output var  logic              input_fault,
	output var  logic              halted,
	output var  logic              busy,
	output var  logic              select_issue,
	// Store requests
	output var  logic              st_valid,
	output var  logic [CODE_W-1:0] st_code,
	output var  logic [ADDR_W-1:0] st_addr,
	output var  logic [WORD_W-1:0] st_data,
	input  wire logic              st_ready
);
	if (DEPTH < 2) begin : g_bad_depth
		$error("ciwa_top DEPTH must be at least 2");
	end

	// ==========================================================
	// Pin synchronisers
	logic [2:0] res_sync_r;
	logic [1:0] disc_sync_r;
	logic       resume_pulse;
	logic [1:0][CHAR_W-1:0] char_sync_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			res_sync_r  <= '0;
			disc_sync_r <= '0;
			char_sync_r <= '0;
		end else begin
			res_sync_r  <= {res_sync_r[1:0], in_resume};
			disc_sync_r <= {disc_sync_r[0], ext_disconnect};
			char_sync_r <= {char_sync_r[0], in_char};
		end
	end

	assign resume_pulse = res_sync_r[1] && !res_sync_r[2];

	// ==========================================================
	// Holding register and store FIFO
	ciwa_strm_if #(.W(CHAR_W))  hold_if ();
	ciwa_strm_if #(.W(ENTRY_W)) st_if ();
	logic               hold_fault;
	logic [ENTRY_W-1:0] fifo_out;

	ciwa_hold u_hold (
		.clk          (clk),
		.reset_n      (reset_n),
		.resume_pulse (resume_pulse),
		.char_in      (char_sync_r[1]),
		.wide_src     (tape_reader_sel),
		.hs           (hold_if.src),
		.fault        (hold_fault)
	);

	ciwa_fifo #(.W(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.wr        (st_if.snk),
		.out_valid (st_valid),
		.out_data  (fifo_out),
		.out_ready (st_ready)
	);

	assign st_code           = fifo_out[ENTRY_W-1 -: CODE_W];
	assign st_addr           = fifo_out[WORD_W +: ADDR_W];
	assign st_data           = fifo_out[WORD_W-1:0];
	assign input_loaded_lamp = hold_if.valid;
	assign input_fault       = hold_fault;

	// ==========================================================
	// Sequence state
	ciwa_state_e       state_r,  state_nxt;
	ciwa_seq_e         seq_r,    seq_nxt;
	logic [ADDR_W-1:0] addr_r,   addr_nxt;
	logic [ADDR_W-1:0] index_r,  index_nxt;
	logic [MODE_W-1:0] mode_r,   mode_nxt;
	logic              wide_r,   wide_nxt;
	logic              rep_r,    rep_nxt;
	logic              enable_r, enable_nxt;
	logic              i2x_r,    i2x_nxt;
	logic              resume_r, resume_nxt;
	logic              disc_r,   disc_nxt;
	logic              sel_r,    sel_nxt;
	logic              halted_r, halted_nxt;
	logic              busy_r,   busy_nxt;
	logic [CHAR_W-1:0] x_r,      x_nxt;
	logic [WORD_W-1:0] q_r,      q_nxt;
	logic              full_word;
	logic              copy;
	logic [WORD_W-1:0] six_ext;
	logic [WORD_W-1:0] st_word;
	ciwa_code_e        st_kind;

	assign full_word = (mode_r == MODE_WORD24) || (mode_r == MODE_LOW15);
	assign copy      = (state_r == ST_WAIT) && i2x_r && resume_r;
	assign six_ext   = {{(WORD_W-SIX_W){1'b0}}, x_r[SIX_W-1:0]};

	// ==========================================================
	// Store word selection
	always_comb begin
		if (full_word) begin
			if (mode_r == MODE_WORD24) begin
				st_word = q_r;
				st_kind = CODE_WORD24;
			end else begin
				st_word = q_r & LOW15_MASK;
				st_kind = CODE_LOW15;
			end
		end else if (wide_r) begin
			st_word = {{(WORD_W-CHAR_W){1'b0}}, x_r};
			st_kind = CODE_CHAR7;
		end else begin
			st_word = six_ext;
			st_kind = CODE_CHAR6;
		end
	end

	assign st_if.data  = {st_kind, addr_r, st_word};
	assign st_if.valid = (state_r == ST_WRITE);
	assign hold_if.ready = copy;

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt  = state_r;
		seq_nxt    = seq_r;
		addr_nxt   = addr_r;
		index_nxt  = index_r;
		mode_nxt   = mode_r;
		wide_nxt   = wide_r;
		rep_nxt    = rep_r;
		enable_nxt = enable_r;
		i2x_nxt    = i2x_r;
		resume_nxt = resume_r;
		disc_nxt   = disc_r;
		sel_nxt    = 1'b0;
		x_nxt      = x_r;
		q_nxt      = q_r;
		if (i2x_r && hold_if.valid && !copy) begin
			resume_nxt = 1'b1;
		end
		case (state_r)
			ST_IDLE: begin
				if (select_fn) begin
					enable_nxt = 1'b1;
				end else if (hold_if.valid) begin
					enable_nxt = 1'b0;
				end
				if (instr_start) begin
					addr_nxt  = addr_in;
					index_nxt = index_in;
					mode_nxt  = store_mode;
					wide_nxt  = tape_reader_sel;
					rep_nxt   = instr_repeat;
					disc_nxt  = 1'b0;
					state_nxt = ST_ARM;
				end
			end
			ST_ARM: begin
				addr_nxt   = addr_r + index_r;
				enable_nxt = 1'b1;
				i2x_nxt    = 1'b1;
				if (full_word) begin
					seq_nxt = SEQ_DD;
					q_nxt   = '0;
				end
				state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (copy) begin
					x_nxt      = hold_if.data;
					resume_nxt = 1'b0;
					i2x_nxt    = 1'b0;
					if (full_word) begin
						case (seq_r)
							SEQ_DD:  seq_nxt = SEQ_DC;
							SEQ_DC:  seq_nxt = SEQ_DB;
							SEQ_DB:  seq_nxt = SEQ_DA;
							default: seq_nxt = SEQ_DD;
						endcase
						state_nxt = ST_ASM;
					end else begin
						if (!rep_r || disc_r) begin
							enable_nxt = 1'b0;
						end
						state_nxt = ST_WRITE;
					end
				end
			end
			ST_ASM: begin
				if (seq_r != SEQ_DD) begin
					q_nxt     = (q_r | six_ext) << SIX_W;
					i2x_nxt   = 1'b1;
					state_nxt = ST_WAIT;
				end else begin
					q_nxt = q_r | six_ext;
					if (!rep_r || disc_r) begin
						enable_nxt = 1'b0;
					end
					state_nxt = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (st_if.ready) begin
					sel_nxt = select_mode;
					if (rep_r && !disc_r) begin
						state_nxt = ST_ARM;
					end else begin
						enable_nxt = 1'b0;
						state_nxt  = ST_IDLE;
					end
				end
			end
			default: begin
				enable_nxt = 1'b0;
				i2x_nxt    = 1'b0;
			end
		endcase
		if (disc_sync_r[1]) begin
			disc_nxt = 1'b1;
		end
		if (hold_fault) begin
			enable_nxt = 1'b0;
			state_nxt  = ST_HALT;
		end
		halted_nxt = (state_nxt == ST_HALT);
		busy_nxt   = (state_nxt != ST_IDLE) && (state_nxt != ST_HALT);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r  <= ST_IDLE;
			seq_r    <= SEQ_DD;
			addr_r   <= '0;
			index_r  <= '0;
			mode_r   <= '0;
			wide_r   <= 1'b0;
			rep_r    <= 1'b0;
			enable_r <= 1'b0;
			i2x_r    <= 1'b0;
			resume_r <= 1'b0;
			disc_r   <= 1'b0;
			sel_r    <= 1'b0;
			halted_r <= 1'b0;
			busy_r   <= 1'b0;
			x_r      <= '0;
			q_r      <= '0;
		end else begin
			state_r  <= state_nxt;
			seq_r    <= seq_nxt;
			addr_r   <= addr_nxt;
			index_r  <= index_nxt;
			mode_r   <= mode_nxt;
			wide_r   <= wide_nxt;
			rep_r    <= rep_nxt;
			enable_r <= enable_nxt;
			i2x_r    <= i2x_nxt;
			resume_r <= resume_nxt;
			disc_r   <= disc_nxt;
			sel_r    <= sel_nxt;
			halted_r <= halted_nxt;
			busy_r   <= busy_nxt;
			x_r      <= x_nxt;
			q_r      <= q_nxt;
		end
	end

	assign in_enable    = enable_r;
	assign halted       = halted_r;
	assign busy         = busy_r;
	assign select_issue = sel_r;

	// ==========================================================
	// Checks
	AST_ARM_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == ST_ARM && !hold_fault) |=> (enable_r && i2x_r && addr_r == $past(addr_r) + $past(index_r)))
		else $error("input instruction did not index address and raise enable");
	AST_RESUME_SET: assert property (@(posedge clk) disable iff (!reset_n)
		(i2x_r && hold_if.valid && !copy) |=> resume_r)
		else $error("held character did not set resume flag");
	AST_COPY: assert property (@(posedge clk) disable iff (!reset_n)
		copy |=> (x_r == $past(hold_if.data) && !resume_r && !hold_if.valid))
		else $error("copy to exchange failed or resume flag stayed set");
	AST_FAULT_HALT: assert property (@(posedge clk) disable iff (!reset_n)
		hold_fault |=> (halted && !in_enable))
		else $error("input fault did not halt");
	AST_SEQ_START: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == ST_ARM && full_word && !hold_fault) |=> (seq_r == SEQ_DD && q_r == '0))
		else $error("full-word start did not clear assembly");
	AST_SEQ_STEP: assert property (@(posedge clk) disable iff (!reset_n)
		(copy && full_word && seq_r == SEQ_DA && !hold_fault) |=> (seq_r == SEQ_DD && state_r == ST_ASM))
		else $error("frame sequence did not wrap to d'd");
	AST_Q_SHIFT: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == ST_ASM && seq_r != SEQ_DD && !hold_fault)
		|=> (q_r[SIX_W-1:0] == '0 && q_r[2*SIX_W-1:SIX_W] == $past(x_r[SIX_W-1:0]) && i2x_r))
		else $error("frame not inserted and shifted");
	AST_NOREP_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
		(copy && !full_word && !rep_r && !hold_fault) |=> (!enable_r && state_r == ST_WRITE))
		else $error("enable not dropped with write on last input");
	AST_REPEAT: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r == ST_WRITE && st_if.ready && rep_r && !disc_r && !hold_fault) |=> (state_r == ST_ARM))
		else $error("repeated input did not restart");
endmodule // ciwa_top

`default_nettype wire

/* File: hw/ciwa_pkg.sv */
// Purpose : Shared constants and types for the character input word assembler
// Assumes : One clock, asynchronous active-low reset
// Notes   : Notes on behaviour below
//
// Notes on behaviour
// - Seven-stage holding register; six-bit sources fill six
// - Clear holding register before each new character
// - Input instruction: index address, then raise enable
// - Pre-arrived character sets resume flag at once
// - Otherwise wait for peripheral resume after enable
// - Second resume before sampling: fault and halt
// - Resume plus input-to-exchange: copy holding to exchange
// - Six-bit source: store six bits, seventh ignored
// - Store mode not 0/4: set write after copy
// - Non-repeated input drops enable with write; short pulse
// - Repeated instruction restarts whole sequence after write
// - Paper-tape reader in character mode stores seven bits
// - Store mode 0/4: pack four six-bit frames
// - Full-word start: sequence to d'd, zero assembly
// - Each frame: copy, step d'c, d'b, d'a, d'd
// - Not d'd: insert six bits, shift left, re-arm
// - Fourth frame: insert without shift, word complete
// - Select-input: lockout sense shows loaded, select again
// - External disconnect ends a repeated input
// - Mode 0 stores 24 bits; mode 4 lower fifteen
`default_nettype none

package ciwa_pkg;
	localparam int CHAR_W  = 7;
	localparam int SIX_W   = 6;
	localparam int WORD_W  = 24;
	localparam int ADDR_W  = 15;
	localparam int MODE_W  = 3;
	localparam int CODE_W  = 2;
	localparam int ENTRY_W = CODE_W + ADDR_W + WORD_W;
	localparam int FIFO_DEPTH = 8;

	localparam logic [MODE_W-1:0] MODE_WORD24 = 3'h0;
	localparam logic [MODE_W-1:0] MODE_LOW15  = 3'h4;
	localparam logic [WORD_W-1:0] LOW15_MASK  = 24'h00_7fff;

	typedef enum logic [1:0] {
		CODE_CHAR6  = 2'b00,
		CODE_CHAR7  = 2'b01,
		CODE_WORD24 = 2'b10,
		CODE_LOW15  = 2'b11
	} ciwa_code_e;

	typedef enum logic [1:0] {
		SEQ_DD = 2'b00,
		SEQ_DC = 2'b01,
		SEQ_DB = 2'b10,
		SEQ_DA = 2'b11
	} ciwa_seq_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ARM   = 3'b001,
		ST_WAIT  = 3'b010,
		ST_ASM   = 3'b011,
		ST_WRITE = 3'b100,
		ST_HALT  = 3'b101
	} ciwa_state_e;
endpackage

`default_nettype wire

/* File: hw/ciwa_strm_if.sv */
// Purpose : Valid/ready word carrier between the assembler's modules
// Assumes : Same clock on both ends
// Notes   : Data qualified by valid; taken when valid and ready
`default_nettype none

interface ciwa_strm_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: hw/ciwa_hold.sv */
// Purpose : Seven-stage input holding register with resume capture
// Assumes : Resume arrives as a synchronised one-cycle pulse
// Notes   : Valid doubles as the loaded lamp and lockout sense
`default_nettype none

module ciwa_hold
	import ciwa_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Peripheral side
	input  wire logic              resume_pulse,
	input  wire logic [CHAR_W-1:0] char_in,
	input  wire logic              wide_src,
	// Held character
	ciwa_strm_if.src               hs,
	output var  logic              fault
);
	logic              valid_r, valid_nxt;
	logic [CHAR_W-1:0] data_r,  data_nxt;
	logic              fault_r, fault_nxt;
	logic              take;

	// ==========================================================
	// Next state
	always_comb begin
		take      = valid_r && hs.ready;
		valid_nxt = valid_r;
		data_nxt  = data_r;
		fault_nxt = fault_r;
		if (take) begin
			valid_nxt = 1'b0;
			data_nxt  = '0;
		end
		if (resume_pulse) begin
			if (valid_r && !take) begin
				fault_nxt = 1'b1;
			end else begin
				valid_nxt = 1'b1;
				data_nxt  = wide_src ? char_in : {1'b0, char_in[SIX_W-1:0]};
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			valid_r <= 1'b0;
			data_r  <= '0;
			fault_r <= 1'b0;
		end else begin
			valid_r <= valid_nxt;
			data_r  <= data_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign hs.valid = valid_r;
	assign hs.data  = data_r;
	assign fault    = fault_r;

	// ==========================================================
	// Checks
	AST_HOLD_FAULT: assert property (@(posedge clk) disable iff (!reset_n)
		(resume_pulse && valid_r && !hs.ready) |=> (fault_r && $stable(data_r)))
		else $error("second resume before sampling did not raise fault");
	AST_HOLD_SIX: assert property (@(posedge clk) disable iff (!reset_n)
		(resume_pulse && !valid_r && !wide_src) |=> (valid_r && !data_r[CHAR_W-1]))
		else $error("six-bit source loaded the seventh stage");
endmodule // ciwa_hold

`default_nettype wire

/* File: hw/ciwa_fifo.sv */
// Purpose : Shift-register FIFO for store requests
// Assumes : Head entry always sits in slot zero
// Notes   : Outputs come straight from slot-zero flip-flops
`default_nettype none

module ciwa_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Fill side
	ciwa_strm_if.snk          wr,
	// Drain side
	output var  logic         out_valid,
	output var  logic [W-1:0] out_data,
	input  wire logic         out_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2) begin : g_bad_depth
		$error("ciwa_fifo DEPTH must be at least 2");
	end

	logic [W-1:0]  mem_r [DEPTH];
	logic [W-1:0]  mem_nxt [DEPTH];
	logic [DEPTH-1:0] vld_r, vld_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          push, pop;
	logic [CW-1:0] wix;

	assign wr.ready = (cnt_r != CW'(DEPTH));

	// ==========================================================
	// Next state
	always_comb begin
		pop  = vld_r[0] && out_ready;
		push = wr.valid && wr.ready;
		wix  = pop ? (cnt_r - CW'(1)) : cnt_r;
		for (int i = 0; i < DEPTH; i++) begin
			if (pop && (i < DEPTH - 1)) begin
				mem_nxt[i] = mem_r[i + 1];
			end else begin
				mem_nxt[i] = mem_r[i];
			end
			if (push && (wix == CW'(i))) begin
				mem_nxt[i] = wr.data;
			end
		end
		cnt_nxt = cnt_r + CW'(push) - CW'(pop);
		for (int i = 0; i < DEPTH; i++) begin
			vld_nxt[i] = (CW'(i) < cnt_nxt);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			vld_r <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			vld_r <= vld_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign out_valid = vld_r[0];
	assign out_data  = mem_r[0];
endmodule // ciwa_fifo

`default_nettype wire

/* File: verif/ciwa_periph.sv */
// Purpose : Peripheral model answering Input Enable with characters
// Assumes : Bench sets base character, width and fault injection
// Notes   : Released data lines show the inverse of the last character
`default_nettype none

module ciwa_periph
	import ciwa_pkg::*;
(
	// Clock and link
	input  wire logic              clk,
	input  wire logic              in_enable,
	input  wire logic              input_loaded_lamp,
	output var  logic [CHAR_W-1:0] in_char,
	output var  logic              in_resume,
	// Bench controls
	input  wire logic [CHAR_W-1:0] char_base,
	input  wire logic              wide,
	input  wire logic              twice,
	output var  int                sent
);
	timeunit 1ns;
	timeprecision 100ps;
	int en_cnt;

	// ==========================================
	// One character with its resume
	task automatic send_one();
		logic [CHAR_W-1:0] v;
		v = char_base + sent[CHAR_W-1:0];
		if (!wide) v[CHAR_W-1] = 1'b0;
		in_char = v;
		in_resume = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		in_resume = 1'b0;
		in_char = ~in_char;
		sent++;
	endtask

	// ==========================================
	// Enable watcher
	initial begin
		in_char = '0;
		in_resume = 1'b0;
		sent = 0;
		en_cnt = 0;
		forever begin
			@(posedge clk);
			#1;
			en_cnt = in_enable ? en_cnt + 1 : 0;
			if (en_cnt >= 6 && input_loaded_lamp !== 1'b1) begin
				repeat ((sent % 3) * 4) begin
					@(posedge clk);
					#1;
				end
				send_one();
				if (twice) begin
					repeat (2) @(posedge clk);
					#1;
					send_one();
				end
				wait (input_loaded_lamp !== 1'b1);
				en_cnt = 0;
			end
		end
	end
endmodule // ciwa_periph

`default_nettype wire

/* File: verif/ciwa_top_bench.sv */
// Purpose : Self-checking bench for the input word assembler
// Assumes : Inputs driven 1 ns after the rising edge
// Notes   : Store requests drained and compared one by one
`default_nettype none

module ciwa_top_bench
	import ciwa_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [ADDR_W-1:0] A1 = 15'h1241;
	logic              clk, reset_n, in_resume, ext_disconnect, in_enable;
	logic              instr_start, instr_repeat, tape_reader_sel, select_mode, select_fn;
	logic              input_loaded_lamp, input_fault, halted, busy, select_issue;
	logic              st_valid, st_ready, pwide, ptwice, tape, sel_seen;
	logic [CHAR_W-1:0] in_char, pbase, c;
	logic [MODE_W-1:0] store_mode;
	logic [ADDR_W-1:0] addr_in, index_in;
	logic [CODE_W-1:0] st_code;
	logic [ADDR_W-1:0] st_addr;
	logic [WORD_W-1:0] st_data, w;
	int                psent, k, n, checks, miscompares, cycles;

	ciwa_top #(.DEPTH(FIFO_DEPTH)) dut_u (.clk(clk), .reset_n(reset_n), .in_char(in_char),
		.in_resume(in_resume), .ext_disconnect(ext_disconnect), .in_enable(in_enable),
		.instr_start(instr_start), .instr_repeat(instr_repeat), .store_mode(store_mode),
		.tape_reader_sel(tape_reader_sel), .addr_in(addr_in), .index_in(index_in),
		.select_mode(select_mode), .select_fn(select_fn), .input_loaded_lamp(input_loaded_lamp),
		.input_fault(input_fault), .halted(halted), .busy(busy), .select_issue(select_issue),
		.st_valid(st_valid), .st_code(st_code), .st_addr(st_addr), .st_data(st_data),
		.st_ready(st_ready));
	ciwa_periph periph_u (.clk(clk), .in_enable(in_enable), .input_loaded_lamp(input_loaded_lamp),
		.in_char(in_char), .in_resume(in_resume), .char_base(pbase), .wide(pwide),
		.twice(ptwice), .sent(psent));

	// ==========================================
	// Clock, select monitor and timeout
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (reset_n !== 1'b1)
			sel_seen <= 1'b0;
		else if (select_issue === 1'b1)
			sel_seen <= 1'b1;
	end
	initial begin
		cycles = 0;
		while (cycles < 20000) begin
			@(posedge clk);
			cycles++;
		end
		miscompares++;
		$display("Error at %0t: timeout", $time);
		conclude();
	end

	// ==========================================
	// Shared tasks
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int cnt);
		repeat (cnt) @(posedge clk);
		#1;
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		ext_disconnect = 1'b0;
		select_fn = 1'b0;
		instr_start = 1'b0;
		st_ready = 1'b0;
		tick(5);
		reset_n = 1'b1;
		tick(1);
	endtask
	task automatic start(input logic [MODE_W-1:0] m, input logic rep, input logic tp);
		store_mode = m;
		instr_repeat = rep;
		tape_reader_sel = tp;
		pwide = tp;
		instr_start = 1'b1;
		tick(1);
		instr_start = 1'b0;
	endtask
	task automatic take(input logic [CODE_W-1:0] cd, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
		int t;
		t = 0;
		while (st_valid !== 1'b1 && t < 3000) begin
			tick(1);
			t++;
		end
		check(st_valid, 1'b1);
		check(st_code, cd);
		check(st_addr, a);
		check(st_data, d);
		st_ready = 1'b1;
		tick(1);
		st_ready = 1'b0;
		tick(1);
	endtask
	task automatic pulse_select();
		select_fn = 1'b1;
		tick(1);
		select_fn = 1'b0;
	endtask
	function automatic logic [CHAR_W-1:0] ch(input int idx, input logic wd);
		ch = pbase + idx[CHAR_W-1:0];
		if (!wd) ch[CHAR_W-1] = 1'b0;
	endfunction
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================
	// Tests
	initial begin
		checks = 0;
		miscompares = 0;
		addr_in = 15'h1230;
		index_in = 15'h0011;
		pbase = 7'h45;
		pwide = 1'b0;
		ptwice = 1'b0;
		select_mode = 1'b0;
		store_mode = '0;
		instr_repeat = 1'b0;
		tape_reader_sel = 1'b0;
		do_reset();
		for (int m = 0; m < 8; m++) begin
			do_reset();
			k = psent;
			tape = m[2] ^ m[0];
			start(m[2:0], 1'b0, tape);
			if (m == 0 || m == 4) begin
				w = '0;
				for (int j = 0; j < 4; j++) begin
					c = ch(k + j, tape);
					w = {w[17:0], c[5:0]};
				end
				take((m == 0) ? CODE_WORD24 : CODE_LOW15, A1, (m == 0) ? w : (w & LOW15_MASK));
			end else begin
				c = ch(k, tape);
				take(tape ? CODE_CHAR7 : CODE_CHAR6, A1, {17'h0_0000, c});
			end
			tick(3);
			check(in_enable, 1'b0);
			check(busy, 1'b0);
			check(sel_seen, 1'b0);
			$display("Test mode %0d done", m);
		end
		do_reset();
		k = psent;
		select_mode = 1'b1;
		pulse_select();
		n = 0;
		while (input_loaded_lamp !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		check(input_loaded_lamp, 1'b1);
		start(3'h2, 1'b0, 1'b0);
		take(CODE_CHAR6, A1, {17'h0_0000, ch(k, 1'b0)});
		tick(5);
		check(sel_seen, 1'b1);
		select_mode = 1'b0;
		$display("Test preload done");
		do_reset();
		k = psent;
		start(3'h1, 1'b1, 1'b0);
		tick(600);
		check(busy, 1'b1);
		ext_disconnect = 1'b1;
		tick(4);
		for (int j = 0; j < 9; j++)
			take(CODE_CHAR6, ADDR_W'(addr_in + index_in * (j + 1)), {17'h0_0000, ch(k + j, 1'b0)});
		tick(40);
		check(busy, 1'b0);
		check(st_valid, 1'b0);
		$display("Test repeat and fill done");
		do_reset();
		ptwice = 1'b1;
		pulse_select();
		tick(100);
		check(input_fault, 1'b1);
		check(halted, 1'b1);
		$display("Test double resume done");
		conclude();
	end
endmodule // ciwa_top_bench

`default_nettype wire
